// >>> logic/tcc_core.sv
`timescale 1ns/1ps
`include "tcc_regs.svh"
// Notes on behaviour
// - Overflow flag sets at modulo: up counting wraps to zero, center counting turns down.
// - Flag clears by reading status while set, then writing zero to it.
// - A new overflow during the clear sequence restarts it; flag stays set.
// - Writing one to the flag does nothing; reset clears flag, enable, center select.
// - Interrupt request while flag and enable are both one.
// - Center select off counts up only; on counts up and down.
// - Clock source field: none, bus, fixed-frequency, external.
// - Prescaler divides selected clock by two to the field value.
// - Prescaler sits after source selection; new value applies next cycle.
// - Reading a counter byte latches both bytes until the other is read.
// - Reset or status write re-arms the counter read latch.
// - Any counter byte write clears the counter and re-arms the latch.
// - Debug active freezes the counter and the read latch state.
// - In debug, status or counter writes still re-arm the read latch.
// - Up counting: at modulo the counter restarts from zero next tick.
// - After one modulo byte write, overflow is suppressed until the other.
// - Reset loads modulo zero, giving a free-running counter.
// - Modulo writes are buffered; with no clock the value applies at once.
// - With a clock, buffered modulo applies on the up-counting step to modulo; in center mode it stays pending.
// - Status writes reset the modulo byte latching, debug or not.
// - In debug, modulo latches hold and writes go straight to modulo.
// - Modulo of all zeros or all ones runs the full 16-bit range.
// - Center mode counts up to modulo then down to zero, repeating.
module tcc_core
    import tcc_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fixedFreqTick,
    input wire logic externalCountClock,
    input wire logic backgroundDebugActive,
    output logic overflowIrq,
    output tcc_cnt_out_t counterOut
);

    logic acc, wrEn, rdEn;
    logic selSc, selCntH, selCntL, selModH, selModL, mapped;
    assign acc = psel && penable;
    assign wrEn = acc && pwrite;
    assign rdEn = acc && !pwrite;
    assign pready = 1'b1;

    always_comb begin
        selSc = 1'b0;
        selCntH = 1'b0;
        selCntL = 1'b0;
        selModH = 1'b0;
        selModL = 1'b0;
        if (paddr == `TCC_ADDR_SC) begin
            selSc = 1'b1;
        end else if (paddr == `TCC_ADDR_CNTH) begin
            selCntH = 1'b1;
        end else if (paddr == `TCC_ADDR_CNTL) begin
            selCntL = 1'b1;
        end else if (paddr == `TCC_ADDR_MODH) begin
            selModH = 1'b1;
        end else if (paddr == `TCC_ADDR_MODL) begin
            selModL = 1'b1;
        end
    end
    assign mapped = selSc | selCntH | selCntL | selModH | selModL;
    assign pslverr = acc && !mapped;

    // External clock: three-stage synchroniser, edge when stages two and three agree
    logic [2:0] extSync_q, extSync_d;
    logic extStable_q, extStable_d;
    logic extRise;
    always_comb begin
        extSync_d = {extSync_q[1:0], externalCountClock};
        extStable_d = extStable_q;
        if (extSync_q[2] == extSync_q[1]) begin
            extStable_d = extSync_q[2];
        end
    end
    assign extRise = (extSync_q[2] == extSync_q[1]) && extSync_q[2] && !extStable_q;

    // Registers
    tcc_ctrl_t ctrl_q, ctrl_d;
    logic ovf_q, ovf_d;
    logic ovfArmed_q, ovfArmed_d;
    logic [15:0] cnt_q, cnt_d;
    logic down_q, down_d;
    logic [6:0] pre_q, pre_d;
    logic [15:0] mod_q, mod_d;
    logic [7:0] modBufH_q, modBufH_d, modBufL_q, modBufL_d;
    logic modHWr_q, modHWr_d, modLWr_q, modLWr_d;
    logic modPend_q, modPend_d;
    tcc_latch_t latch_q, latch_d;
    logic [15:0] snap_q, snap_d;
    logic [31:0] prdata_q, prdata_d;

    logic srcTick, tick, freeRun, atTop, wrap, modHalf;
    logic [7:0] preMask;
    logic [15:0] nextCnt;

    always_comb begin
        case (ctrl_q.clockSourceSel)
            `TCC_CLK_BUS: srcTick = 1'b1;
            `TCC_CLK_FIXED: srcTick = fixedFreqTick;
            `TCC_CLK_EXT: srcTick = extRise;
            default: srcTick = 1'b0;
        endcase
    end
    // Prescaler follows the selected source; mask from current register bits
    assign preMask = 8'(`TCC_PS_MAX >> (3'h7 - ctrl_q.prescaleSel));
    assign tick = srcTick && ((pre_q & preMask[6:0]) == preMask[6:0]) && !backgroundDebugActive;
    assign freeRun = (mod_q == `TCC_CNT_ZERO) || (mod_q == `TCC_CNT_ALL);
    assign atTop = freeRun ? (cnt_q == `TCC_CNT_ALL) : (cnt_q == mod_q);
    assign modHalf = modHWr_q ^ modLWr_q;
    logic [15:0] modBuf, modNext;
    // A buffered zero means free-running, so it lands on the step into the top count
    assign modBuf = {modBufH_q, modBufL_q};
    assign modNext = (modBuf == `TCC_CNT_ZERO) ? `TCC_CNT_ALL : modBuf;

    always_comb begin
        nextCnt = cnt_q + `TCC_CNT_ONE;
        wrap = 1'b0;
        down_d = down_q;
        if (ctrl_q.centerPwmSelect) begin
            if (down_q) begin
                nextCnt = cnt_q - `TCC_CNT_ONE;
                if (cnt_q == `TCC_CNT_ONE) begin
                    down_d = 1'b0;
                end
                if (cnt_q == `TCC_CNT_ZERO) begin
                    nextCnt = `TCC_CNT_ONE;
                    down_d = 1'b0;
                end
            end else if (atTop) begin
                nextCnt = cnt_q - `TCC_CNT_ONE;
                down_d = 1'b1;
                wrap = 1'b1;
            end
        end else begin
            down_d = 1'b0;
            if (atTop) begin
                nextCnt = `TCC_CNT_ZERO;
                wrap = 1'b1;
            end
        end
        if (!tick) begin
            down_d = down_q;
        end
        if (wrEn && (selCntH || selCntL)) begin
            down_d = 1'b0;
        end
    end

    always_comb begin
        ctrl_d = ctrl_q;
        ovf_d = ovf_q;
        ovfArmed_d = ovfArmed_q;
        cnt_d = cnt_q;
        pre_d = tick || !srcTick ? pre_q : 7'(pre_q + 7'h01);
        mod_d = mod_q;
        modBufH_d = modBufH_q;
        modBufL_d = modBufL_q;
        modHWr_d = modHWr_q;
        modLWr_d = modLWr_q;
        modPend_d = modPend_q;
        latch_d = latch_q;
        snap_d = snap_q;
        prdata_d = prdata_q;
        if (tick) begin
            pre_d = 7'h00;
            cnt_d = nextCnt;
        end
        if (ctrl_q.clockSourceSel == `TCC_CLK_NONE) begin
            pre_d = 7'h00;
        end
        // Buffered modulo applies on the step into the new top count
        if (tick && modPend_q && !ctrl_q.centerPwmSelect && nextCnt == modNext) begin
            mod_d = {modBufH_q, modBufL_q};
            modPend_d = 1'b0;
        end
        // Status read while set arms the clear
        if (rdEn && selSc && ovf_q) begin
            ovfArmed_d = 1'b1;
        end
        // Reads: coherent counter snapshot
        if (rdEn) begin
            prdata_d = 32'h0000_0000;
            if (selSc) begin
                prdata_d[7:0] = {ovf_q, ctrl_q};
            end else if (selCntH || selCntL) begin
                if (latch_q == TCC_LATCH_IDLE) begin
                    prdata_d[7:0] = selCntH ? cnt_q[15:8] : cnt_q[7:0];
                    if (!backgroundDebugActive) begin
                        snap_d = cnt_q;
                        latch_d = selCntH ? TCC_LATCH_HIGH : TCC_LATCH_LOW;
                    end
                end else begin
                    prdata_d[7:0] = selCntH ? snap_q[15:8] : snap_q[7:0];
                    if (!backgroundDebugActive
                            && ((latch_q == TCC_LATCH_HIGH) == selCntL)) begin
                        latch_d = TCC_LATCH_IDLE;
                    end
                end
            end else if (selModH) begin
                prdata_d[7:0] = mod_q[15:8];
            end else if (selModL) begin
                prdata_d[7:0] = mod_q[7:0];
            end
        end
        if (wrEn && selSc) begin
            ctrl_d = pwdata[`TCC_SC_OVIE:`TCC_SC_PS_LO];
            if (!pwdata[`TCC_SC_OVF] && ovfArmed_q) begin
                ovf_d = 1'b0;
            end
            ovfArmed_d = 1'b0;
            latch_d = TCC_LATCH_IDLE;
            modHWr_d = 1'b0;
            modLWr_d = 1'b0;
        end
        if (wrEn && (selCntH || selCntL)) begin
            cnt_d = `TCC_CNT_ZERO;
            pre_d = 7'h00;
            latch_d = TCC_LATCH_IDLE;
        end
        if (wrEn && (selModH || selModL)) begin
            if (backgroundDebugActive) begin
                if (selModH) begin
                    mod_d[15:8] = pwdata[7:0];
                end else begin
                    mod_d[7:0] = pwdata[7:0];
                end
            end else begin
                if (selModH) begin
                    modBufH_d = pwdata[7:0];
                    modHWr_d = 1'b1;
                end else begin
                    modBufL_d = pwdata[7:0];
                    modLWr_d = 1'b1;
                end
                if ((selModH && modLWr_q) || (selModL && modHWr_q)) begin
                    modHWr_d = 1'b0;
                    modLWr_d = 1'b0;
                    if (ctrl_q.clockSourceSel == `TCC_CLK_NONE) begin
                        mod_d = selModH ? {pwdata[7:0], modBufL_q} : {modBufH_q, pwdata[7:0]};
                    end else begin
                        modPend_d = 1'b1;
                    end
                end
            end
        end
        // Overflow sets and disarms the clear sequence; set wins over clear
        if (tick && wrap && !modHalf) begin
            ovf_d = 1'b1;
            ovfArmed_d = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            extSync_q <= 3'h0;
            extStable_q <= 1'b0;
            ctrl_q <= '0;
            ovf_q <= 1'b0;
            ovfArmed_q <= 1'b0;
            cnt_q <= `TCC_CNT_ZERO;
            down_q <= 1'b0;
            pre_q <= 7'h00;
            mod_q <= `TCC_MOD_RESET;
            modBufH_q <= 8'h00;
            modBufL_q <= 8'h00;
            modHWr_q <= 1'b0;
            modLWr_q <= 1'b0;
            modPend_q <= 1'b0;
            latch_q <= TCC_LATCH_IDLE;
            snap_q <= `TCC_CNT_ZERO;
            prdata_q <= 32'h0000_0000;
        end else begin
            extSync_q <= extSync_d;
            extStable_q <= extStable_d;
            ctrl_q <= ctrl_d;
            ovf_q <= ovf_d;
            ovfArmed_q <= ovfArmed_d;
            cnt_q <= cnt_d;
            down_q <= down_d;
            pre_q <= pre_d;
            mod_q <= mod_d;
            modBufH_q <= modBufH_d;
            modBufL_q <= modBufL_d;
            modHWr_q <= modHWr_d;
            modLWr_q <= modLWr_d;
            modPend_q <= modPend_d;
            latch_q <= latch_d;
            snap_q <= snap_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata = rdEn ? prdata_d : prdata_q;
    assign overflowIrq = ovf_q && ctrl_q.ovfIrqEnable;
    assign counterOut = '{count: cnt_q, countDown: down_q, centerPwm: ctrl_q.centerPwmSelect};

    // Assertions
    irq_on_wrap_a: assert property (@(posedge clock) disable iff (rst)
        tick && wrap && !modHalf && ctrl_q.ovfIrqEnable && !(wrEn && selSc) |=> overflowIrq)
        else $error("overflow did not raise irq");
    cnt_clear_a: assert property (@(posedge clock) disable iff (rst)
        wrEn && (selCntH || selCntL) |=> cnt_q == `TCC_CNT_ZERO) else $error("counter not cleared");
    debug_freeze_a: assert property (@(posedge clock) disable iff (rst)
        backgroundDebugActive && !wrEn |=> $stable(cnt_q)) else $error("counter moved in debug");
    one_no_clear_a: assert property (@(posedge clock) disable iff (rst)
        ovf_q && wrEn && selSc && pwdata[`TCC_SC_OVF] |=> ovf_q) else $error("write one cleared flag");
    ovf_set_a: assert property (@(posedge clock) disable iff (rst)
        tick && wrap && !modHalf |=> ovf_q) else $error("overflow not flagged");
    up_wrap_a: assert property (@(posedge clock) disable iff (rst)
        tick && !ctrl_q.centerPwmSelect && atTop && !wrEn |=> cnt_q == `TCC_CNT_ZERO)
        else $error("no wrap at modulo");
    clear_needs_read_a: assert property (@(posedge clock) disable iff (rst)
        ovf_q && !ovfArmed_q && !(rdEn && selSc) |=> ovf_q) else $error("flag cleared without read");
    sc_rearm_a: assert property (@(posedge clock) disable iff (rst)
        wrEn && selSc |=> latch_q == TCC_LATCH_IDLE && !modHWr_q && !modLWr_q)
        else $error("latches not rearmed");
    half_mod_a: assert property (@(posedge clock) disable iff (rst)
        modHalf && !wrEn |=> $stable(ovf_q) || !ovf_q) else $error("overflow during half modulo");
    idle_mod_a: assert property (@(posedge clock) disable iff (rst)
        ctrl_q.clockSourceSel == `TCC_CLK_NONE && wrEn && selModL && modHWr_q && !backgroundDebugActive
        |=> mod_q[7:0] == $past(pwdata[7:0])) else $error("modulo not applied");
    mod_apply_a: assert property (@(posedge clock) disable iff (rst)
        tick && modPend_q && !ctrl_q.centerPwmSelect && nextCnt == modNext && !wrEn
        |=> mod_q == $past(modBuf) && !modPend_q) else $error("buffered modulo not applied");
    snap_hold_a: assert property (@(posedge clock) disable iff (rst)
        latch_q != TCC_LATCH_IDLE |=> $stable(snap_q)) else $error("counter snapshot changed");
    debug_mod_a: assert property (@(posedge clock) disable iff (rst)
        backgroundDebugActive && wrEn && selModL |=> mod_q[7:0] == $past(pwdata[7:0]) && $stable(modLWr_q))
        else $error("debug modulo write not direct");
    stop_clk_a: assert property (@(posedge clock) disable iff (rst)
        ctrl_q.clockSourceSel == `TCC_CLK_NONE |-> !tick) else $error("counter ticked with no clock");

endmodule : tcc_core

// >>> shared/tcc_regs.svh
`ifndef TCC_REGS_SVH
`define TCC_REGS_SVH

// Byte addresses on the APB bus (one aligned word each)
`define TCC_ADDR_SC 12'h000
`define TCC_ADDR_CNTH 12'h004
`define TCC_ADDR_CNTL 12'h008
`define TCC_ADDR_MODH 12'h00C
`define TCC_ADDR_MODL 12'h010

// Status/control field positions
`define TCC_SC_OVF 7
`define TCC_SC_OVIE 6
`define TCC_SC_CPWM 5
`define TCC_SC_CLKS_HI 4
`define TCC_SC_CLKS_LO 3
`define TCC_SC_PS_HI 2
`define TCC_SC_PS_LO 0

// Clock source codes
`define TCC_CLK_NONE 2'h0
`define TCC_CLK_BUS 2'h1
`define TCC_CLK_FIXED 2'h2
`define TCC_CLK_EXT 2'h3

`define TCC_CNT_ZERO 16'h0000
`define TCC_CNT_ONE 16'h0001
`define TCC_CNT_ALL 16'hFFFF
`define TCC_MOD_RESET 16'h0000
`define TCC_PS_MAX 8'h7F

`endif

// >>> shared/tcc_pkg.sv
package tcc_pkg;

    typedef struct packed {
        logic ovfIrqEnable;
        logic centerPwmSelect;
        logic [1:0] clockSourceSel;
        logic [2:0] prescaleSel;
    } tcc_ctrl_t;

    typedef struct packed {
        logic [15:0] count;
        logic countDown;
        logic centerPwm;
    } tcc_cnt_out_t;

    typedef enum logic [1:0] {
        TCC_LATCH_IDLE = 2'b00,
        TCC_LATCH_HIGH = 2'b01,
        TCC_LATCH_LOW = 2'b10
    } tcc_latch_t;

endpackage : tcc_pkg

// >>> verif/tb_timer_counter_core_regs.sv
`timescale 1ns/1ps
`include "tcc_regs.svh"
module tb_timer_counter_core_regs
    import tcc_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic fixedFreqTick = 1'b0;
    logic externalCountClock = 1'b0;
    logic backgroundDebugActive = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic overflowIrq;
    tcc_cnt_out_t counterOut;
    int mismatches = 0;
    int compares = 0;
    integer seed = 32'h052D;
    // Bench model of the counter and its flag
    logic [15:0] modA = 16'h0000;
    logic [15:0] pv = 16'h0000;
    logic [15:0] rd;
    logic [15:0] cs;
    logic err;
    bit pend = 0;
    bit inh = 0;
    bit mFlag = 0;
    bit cp = 0;
    bit dn = 0;

    always #5 clock = ~clock;

    tcc_core DUT (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .fixedFreqTick(fixedFreqTick),
        .externalCountClock(externalCountClock), .backgroundDebugActive(backgroundDebugActive),
        .overflowIrq(overflowIrq), .counterOut(counterOut));

    task stop_test;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task chkv(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chkv

    task chkb(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %b seen %b", n, e, g);
        end
    endtask : chkb

    // One APB transfer; upper write-data bits carry random filler
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        r = $random(seed);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {r[31:8], d};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        // Data and the counter are taken at the completing edge
        rd = prdata[15:0];
        cs = counterOut.count;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rx(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chkv("read", {8'h00, e}, rd);
    endtask : rx

    // Steps the bus-clock counter and compares every new value with the model
    task run(input int n);
        logic [15:0] p;
        logic [15:0] c;
        logic [15:0] e;
        @(negedge clock);
        p = counterOut.count;
        repeat (n) begin
            @(negedge clock);
            c = counterOut.count;
            if (!cp) begin
                if ((modA != 16'h0000 && p == modA) || p == 16'hFFFF) begin
                    e = 16'h0000;
                    if (!inh) mFlag = 1;
                end else e = p + 16'h0001;
                if (pend && e == pv) begin
                    modA = pv;
                    pend = 0;
                end
            end else if (!dn) begin
                if (p == modA) begin
                    dn = 1;
                    mFlag = 1;
                    e = p - 16'h0001;
                end else e = p + 16'h0001;
            end else if (p == 16'h0000) begin
                dn = 0;
                e = 16'h0001;
            end else e = p - 16'h0001;
            chkv("count", e, c);
            chkb("centerPwm", cp, counterOut.centerPwm);
            if (c != 16'h0000 && c != modA) chkb("countDown", cp & dn, counterOut.countDown);
            p = c;
        end
    endtask : run

    initial begin
        #200000;
        mismatches++;
        stop_test();
    end

    initial begin
        logic [15:0] c;
        logic [15:0] lo;
        int k;
        int n;
        logic [31:0] t;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) rx(12'(4 * i), 8'h00);
        rx(12'h014, 8'h00);
        chkb("slverr", 1'b1, err);
        wr(`TCC_ADDR_MODH, 8'h00);
        wr(`TCC_ADDR_MODL, 8'h09);
        modA = 16'h0009;
        rx(`TCC_ADDR_MODL, 8'h09);
        repeat (10) @(negedge clock);
        chkv("stopped", 16'h0000, counterOut.count);
        wr(`TCC_ADDR_SC, 8'h48);
        run(40);
        chkb("irq", 1'b1, overflowIrq);
        rx(`TCC_ADDR_SC, 8'hC8);
        run(12);
        wr(`TCC_ADDR_SC, 8'h48);
        @(negedge clock);
        chkb("irq", 1'b1, overflowIrq);
        wr(`TCC_ADDR_SC, 8'hC0);
        @(negedge clock);
        chkb("irq", 1'b1, overflowIrq);
        rx(`TCC_ADDR_SC, 8'hC0);
        wr(`TCC_ADDR_SC, 8'h00);
        @(negedge clock);
        chkb("irq", 1'b0, overflowIrq);
        mFlag = 0;
        wr(`TCC_ADDR_MODL, 8'h00);
        wr(`TCC_ADDR_MODH, 8'h00);
        modA = 16'h0000;
        wr(`TCC_ADDR_SC, 8'h08);
        wr(`TCC_ADDR_CNTL, 8'h5A);
        @(negedge clock);
        chkb("cleared", 1'b1, counterOut.count < 16'h0003);
        run(300);
        apb(1'b0, `TCC_ADDR_CNTL, 8'h00);
        lo = rd;
        c = cs;
        run(20);
        apb(1'b0, `TCC_ADDR_CNTH, 8'h00);
        chkv("pairLowFirst", c, {rd[7:0], lo[7:0]});
        apb(1'b0, `TCC_ADDR_CNTH, 8'h00);
        lo = rd;
        c = cs;
        run(20);
        apb(1'b0, `TCC_ADDR_CNTL, 8'h00);
        chkv("pairHighFirst", c, {lo[7:0], rd[7:0]});
        apb(1'b0, `TCC_ADDR_CNTH, 8'h00);
        wr(`TCC_ADDR_SC, 8'h08);
        apb(1'b0, `TCC_ADDR_CNTL, 8'h00);
        chkv("rearm", {8'h00, cs[7:0]}, rd);
        apb(1'b0, `TCC_ADDR_CNTH, 8'h00);
        apb(1'b0, `TCC_ADDR_CNTL, 8'h00);
        c = cs;
        backgroundDebugActive <= 1'b1;
        repeat (2) @(negedge clock);
        lo = counterOut.count;
        repeat (10) @(negedge clock);
        chkv("frozen", lo, counterOut.count);
        rx(`TCC_ADDR_CNTH, c[15:8]);
        @(posedge clock);
        backgroundDebugActive <= 1'b0;
        rx(`TCC_ADDR_CNTH, c[15:8]);
        apb(1'b0, `TCC_ADDR_CNTL, 8'h00);
        @(posedge clock);
        backgroundDebugActive <= 1'b1;
        wr(`TCC_ADDR_CNTH, 8'h3C);
        rx(`TCC_ADDR_CNTL, 8'h00);
        wr(`TCC_ADDR_MODH, 8'h00);
        wr(`TCC_ADDR_MODL, 8'h10);
        modA = 16'h0010;
        @(posedge clock);
        backgroundDebugActive <= 1'b0;
        run(60);
        rx(`TCC_ADDR_SC, 8'h88);
        wr(`TCC_ADDR_SC, 8'h80);
        rx(`TCC_ADDR_SC, 8'h80);
        wr(`TCC_ADDR_SC, 8'h00);
        mFlag = 0;
        wr(`TCC_ADDR_MODL, 8'h40);
        wr(`TCC_ADDR_MODH, 8'h00);
        modA = 16'h0040;
        wr(`TCC_ADDR_SC, 8'h08);
        wr(`TCC_ADDR_MODH, 8'h00);
        inh = 1;
        run(200);
        rx(`TCC_ADDR_SC, {mFlag, 7'h08});
        wr(`TCC_ADDR_MODL, 8'h20);
        inh = 0;
        pend = 1;
        pv = 16'h0020;
        run(200);
        rx(`TCC_ADDR_SC, 8'h88);
        for (int ps = 0; ps < 8; ps++) begin
            wr(`TCC_ADDR_SC, {5'b00001, 3'(ps)});
            for (int j = 0; j < 2; j++) begin
                c = counterOut.count;
                k = 0;
                while (counterOut.count === c && k < 300) begin
                    @(negedge clock);
                    k++;
                end
            end
            chkv("tickGap", 16'(1 << ps), 16'(k));
        end
        wr(`TCC_ADDR_SC, 8'h00);
        wr(`TCC_ADDR_CNTL, 8'h00);
        wr(`TCC_ADDR_SC, 8'h10);
        n = 0;
        repeat (100) begin
            @(posedge clock);
            t = $random(seed);
            fixedFreqTick <= t[0];
            n += t[0];
        end
        @(posedge clock);
        fixedFreqTick <= 1'b0;
        repeat (4) @(negedge clock);
        chkv("fixedCount", 16'(n % 33), counterOut.count);
        wr(`TCC_ADDR_SC, 8'h00);
        wr(`TCC_ADDR_CNTL, 8'h00);
        wr(`TCC_ADDR_SC, 8'h18);
        repeat (20) begin
            repeat (4) @(posedge clock);
            externalCountClock <= 1'b1;
            repeat (4) @(posedge clock);
            externalCountClock <= 1'b0;
        end
        repeat (10) @(negedge clock);
        chkv("extCount", 16'h0014, counterOut.count);
        wr(`TCC_ADDR_SC, 8'h00);
        wr(`TCC_ADDR_CNTL, 8'h00);
        cp = 1;
        dn = 0;
        wr(`TCC_ADDR_SC, 8'h28);
        run(100);
        stop_test();
    end
endmodule : tb_timer_counter_core_regs
